// ---- bench/mfr_board.sv ----
`timescale 1ns/100ps
module mfr_board
  import mfr_pkg::*;
(
  input wire logic [NUM_PINS-1:0] mf_pin_out,
  input wire logic [NUM_PINS-1:0] mf_pin_oe,
  input wire logic [NUM_PINS-1:0] ext_val,
  input wire logic [NUM_PINS-1:0] ext_en,
  output logic [NUM_PINS-1:0] mf_pin_level
);
  // board pull-ups: a released line reads ext_val where ext_en is set, else high, never the last driven value
  always_comb
  begin
    for (int k = 0; k < NUM_PINS; k++)
    begin
      mf_pin_level[k] = mf_pin_oe[k] ? mf_pin_out[k] : (ext_en[k] ? ext_val[k] : 1'h1);
    end
  end
endmodule // mfr_board

// ---- bench/multifunction_pin_routing_bench.sv ----
`timescale 1ns/100ps
module multifunction_pin_routing_bench
  import mfr_pkg::*;
();
  logic ref_clk, rst_n, pci_bus_reset_n, suspend, serial_strap_n, avs_read, avs_write, avs_waitrequest, sel;
  logic host_speaker_output, ring_indicate_output;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  mfr_core_t core_in;
  mfr_ret_t core_ret;
  logic [NUM_PINS-1:0] mf_pin_in, mf_pin_out, mf_pin_oe, ext_val, ext_en, exp_oe, exp_out, lv;
  logic [1:0] card_speaker_input;
  logic [27:0] route;
  logic [4:0] gp;
  integer seed = 32'h9a43;
  int miscompares, comparisons;

  mfr_pin_router u_mfr_pin_router (.ref_clk(ref_clk), .rst_n(rst_n), .pci_bus_reset_n(pci_bus_reset_n),
    .suspend(suspend), .serial_strap_n(serial_strap_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .core_in(core_in), .core_ret(core_ret), .mf_pin_in(mf_pin_in),
    .mf_pin_out(mf_pin_out), .mf_pin_oe(mf_pin_oe), .card_speaker_input(card_speaker_input),
    .host_speaker_output(host_speaker_output), .ring_indicate_output(ring_indicate_output));

  mfr_board u_mfr_board (.mf_pin_out(mf_pin_out), .mf_pin_oe(mf_pin_oe), .ext_val(ext_val),
    .ext_en(ext_en), .mf_pin_level(mf_pin_in));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // request held until waitrequest seen low at an edge
  task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= we;
    avs_read <= ~we;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'h0 && n < 50);
    if (n >= 50)
      chk(32'h1, 32'h0);
    r = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    // idle edge so the next request never re-drives in the same step
    @(posedge ref_clk);
  endtask

  task automatic pulse(input logic pci);
    if (pci)
      pci_bus_reset_n <= 1'h0;
    else
      rst_n <= 1'h0;
    repeat (5) @(posedge ref_clk);
    pci_bus_reset_n <= 1'h1;
    rst_n <= 1'h1;
    repeat (4) @(posedge ref_clk);
  endtask

  // returns {oe, out} expected on pin k
  function automatic logic [1:0] pin_model(input int k, input logic [3:0] c, input logic [4:0] g);
    if (!PIN_ALLOWED[k][c])
      return 2'h0;
    case (c)
      4'h1: return {1'h1, core_in.par_irq[k]};
      4'h3: return {1'h1, g[PIN_GP_IDX[k]]};
      4'h4: return {1'h1, core_in.led};
      4'h5: return {1'h1, core_in.video_sw};
      4'h6: return {1'h1, core_in.audio_pwm};
      4'h7: return {1'h1, core_in.gp_event};
      4'h8: return {1'h1, core_in.ring};
      4'h9: return {1'h1, core_in.low_power};
      4'ha: return {core_in.pci_int[k], 1'h0};
      4'hb: return {core_in.lock_oe, core_in.lock_o};
      4'hc: return {core_in.clkrun_oe, core_in.clkrun_o};
      4'hd: return {core_in.serirq_oe, core_in.serirq_o};
      default: return 2'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    rst_n = 1'h0;
    pci_bus_reset_n = 1'h1;
    suspend = 1'h0;
    serial_strap_n = 1'h1;
    avs_address = '0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    core_in = '0;
    ext_val = '0;
    ext_en = '0;
    card_speaker_input = 2'h0;
    miscompares = 0;
    comparisons = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    bus(1'h0, REG_ROUTE, 32'h0, rd);
    chk(rd, {4'h0, ROUTE_RST});
    bus(1'h0, 5'h14, 32'h0, rd);
    chk(rd, 32'h0);
    // first 16 passes set every code on every pin, then random mixes
    for (int i = 0; i < 40; i++)
    begin
      route = (i < 16) ? {7{i[3:0]}} : 28'($random(seed));
      gp = 5'($random(seed));
      sel = 1'($random(seed));
      core_in <= $bits(mfr_core_t)'($random(seed));
      card_speaker_input <= 2'($random(seed));
      ext_val <= 7'($random(seed));
      ext_en <= 7'($random(seed));
      bus(1'h1, REG_GP_OUT, {27'h0, gp}, rd);
      bus(1'h1, REG_CTRL, {31'h0, sel}, rd);
      bus(1'h1, REG_ROUTE, {4'h0, route}, rd);
      repeat (4) @(posedge ref_clk);
      for (int k = 0; k < NUM_PINS; k++)
      begin
        {exp_oe[k], exp_out[k]} = pin_model(k, route[4*k +: 4], gp);
        lv[k] = exp_oe[k] ? exp_out[k] : (ext_en[k] ? ext_val[k] : 1'h1);
      end
      chk(32'(mf_pin_oe), 32'(exp_oe));
      chk(32'(mf_pin_out & exp_oe), 32'(exp_out & exp_oe));
      chk(32'(host_speaker_output), 32'(^card_speaker_input));
      chk(32'(ring_indicate_output), 32'(sel ? core_in.pme : core_in.ring));
      bus(1'h0, REG_GP_IN, 32'h0, rd);
      chk(rd, {27'h0, lv[5], lv[4], lv[2], lv[1], lv[0]});
      chk(32'(core_ret), 32'({lv[4], lv[6], lv[3]}));
    end
    // both resets, with and without suspend
    for (int j = 0; j < 4; j++)
    begin
      suspend <= j[1];
      bus(1'h1, REG_GP_OUT, 32'h15, rd);
      repeat (4) @(posedge ref_clk);
      pulse(j[0]);
      bus(1'h0, REG_GP_OUT, 32'h0, rd);
      chk(rd, j[1] ? 32'h15 : 32'h0);
    end
    suspend <= 1'h0;
    // no eeprom fitted: pull-up gives a nack on the first byte
    // board drivers off, else a random low on sda would fake an ack
    ext_en <= '0;
    serial_strap_n <= 1'h0;
    repeat (4) @(posedge ref_clk);
    pulse(1'h0);
    bus(1'h1, REG_GP_OUT, 32'h1f, rd);
    bus(1'h1, REG_ROUTE, 32'h30030, rd);
    n = 0;
    rd = 32'h0;
    while (rd[STAT_LD_ERR_BIT] !== 1'h1 && n < 100)
    begin
      repeat (200) @(posedge ref_clk);
      chk(32'(mf_pin_out & mf_pin_oe & 7'h12), 32'h0);
      bus(1'h0, REG_CTRL, 32'h0, rd);
      n++;
    end
    chk(32'(rd[STAT_SERIAL_EN_BIT]), 32'h1);
    chk(32'(rd[STAT_LD_ERR_BIT]), 32'h1);
    bus(1'h0, REG_SUBSYS, 32'h0, rd);
    chk(rd, 32'h0);
    test_done();
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end
endmodule // multifunction_pin_routing_bench

// ---- core/mfr_eeprom_loader.sv ----
`timescale 1ns/100ps
module mfr_eeprom_loader
  import mfr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic sda_in,
  output logic scl_oe,
  output logic sda_oe,
  output logic busy,
  output logic done,
  output logic err,
  output logic [31:0] data
);

  function automatic logic [7:0] ee_byte(input logic [2:0] frame);
    ee_byte = (frame == 3'h0) ? EE_DEV_WR : (frame == 3'h1) ? EE_WORD_ADDR : EE_DEV_RD;
  endfunction

  mfr_ld_state_t s_reg;
  mfr_ld_state_t s_next;
  logic tick;
  logic rd;
  logic last;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_next = s_reg;
    tick = (s_reg.qcnt == QUARTER_CNT_MAX);
    rd = (s_reg.frame >= EE_FIRST_READ);
    last = (s_reg.frame == EE_LAST_FRAME);
    if (s_reg.fsm != LD_IDLE && s_reg.fsm != LD_DONE)
    begin
      s_next.qcnt = tick ? 8'h00 : s_reg.qcnt + 8'h01;
      if (tick)
        s_next.q = s_reg.q + 2'h1;
    end
    case (s_reg.fsm)
      LD_IDLE, LD_DONE:
        if (start)
        begin
          s_next.fsm = LD_START;
          s_next.qcnt = 8'h00;
          s_next.q = 2'h0;
          s_next.frame = 3'h0;
          s_next.err = 1'b0;
          s_next.done = 1'b0;
        end
      LD_START:
        // also serves as repeated start: release sda before scl
        if (tick)
          case (s_reg.q)
            2'h0: s_next.sda_oe = 1'b0;
            2'h1: s_next.scl_oe = 1'b0;
            2'h2: s_next.sda_oe = 1'b1;
            default:
            begin
              s_next.scl_oe = 1'b1;
              s_next.fsm = LD_BIT;
              s_next.bit_i = 4'h0;
              s_next.shreg = ee_byte(s_reg.frame);
            end
          endcase
      LD_BIT:
        if (tick)
          case (s_reg.q)
            2'h0:
              if (s_reg.bit_i < 4'h8)
                s_next.sda_oe = !rd && !s_reg.shreg[7];
              else
                s_next.sda_oe = rd && !last;
            2'h1: s_next.scl_oe = 1'b0;
            2'h2:
            begin
              if (rd && s_reg.bit_i < 4'h8)
                s_next.shreg = {s_reg.shreg[6:0], sda_in};
              if (!rd && s_reg.bit_i == 4'h8 && sda_in)
                s_next.err = 1'b1;
            end
            default:
            begin
              s_next.scl_oe = 1'b1;
              if (s_reg.bit_i == 4'h8)
              begin
                s_next.bit_i = 4'h0;
                if (rd)
                  s_next.data = {s_reg.data[23:0], s_reg.shreg};
                if (s_reg.err || last)
                  s_next.fsm = LD_STOP;
                else
                begin
                  s_next.frame = s_reg.frame + 3'h1;
                  s_next.shreg = ee_byte(s_next.frame);
                  if (s_next.frame == EE_RESTART_FRAME)
                    s_next.fsm = LD_START;
                end
              end
              else
              begin
                s_next.bit_i = s_reg.bit_i + 4'h1;
                if (!rd)
                  s_next.shreg = {s_reg.shreg[6:0], 1'b0};
              end
            end
          endcase
      LD_STOP:
        if (tick)
          case (s_reg.q)
            2'h0: s_next.sda_oe = 1'b1;
            2'h1: s_next.scl_oe = 1'b0;
            2'h2: s_next.sda_oe = 1'b0;
            default:
            begin
              s_next.fsm = LD_DONE;
              s_next.done = 1'b1;
            end
          endcase
      default: s_next.fsm = LD_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign scl_oe = s_reg.scl_oe;
  assign sda_oe = s_reg.sda_oe;
  assign busy = (s_reg.fsm != LD_IDLE) && (s_reg.fsm != LD_DONE);
  assign done = s_reg.done;
  assign err = s_reg.err;
  assign data = s_reg.data;
endmodule // mfr_eeprom_loader

// ---- core/mfr_pin_router.sv ----
`timescale 1ns/100ps
module mfr_pin_router
  import mfr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pci_bus_reset_n,
  input wire logic suspend,
  input wire logic serial_strap_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire mfr_core_t core_in,
  output mfr_ret_t core_ret,
  input wire logic [NUM_PINS-1:0] mf_pin_in,
  output logic [NUM_PINS-1:0] mf_pin_out,
  output logic [NUM_PINS-1:0] mf_pin_oe,
  input wire logic [1:0] card_speaker_input,
  output logic host_speaker_output,
  output logic ring_indicate_output
);

  mfr_state_t s_reg;
  mfr_state_t s_next;
  logic [11:0] sync_q;
  logic [NUM_PINS-1:0] pin_s;
  logic suspend_s;
  logic pci_bus_reset_n_s;
  logic strap_s;
  logic [1:0] spk_s;
  logic reset_active;
  logic do_clear;
  logic req;
  logic ld_start;
  logic ld_scl_oe;
  logic ld_sda_oe;
  logic ld_busy;
  logic ld_done;
  logic ld_err;
  logic [31:0] ld_data;
  logic [GP_W-1:0] gp_in;
  logic [31:0] rd;
  logic [31:0] wmerge;
  logic [31:0] wold;
  mfr_func_t func;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and the eeprom loader
  mfr_sync #(.W(12)) u_sync (
    .ref_clk(ref_clk),
    .d({suspend, pci_bus_reset_n, serial_strap_n, card_speaker_input, mf_pin_in}),
    .q(sync_q)
  );

  assign pin_s = sync_q[6:0];
  assign spk_s = sync_q[8:7];
  assign strap_s = sync_q[9];
  assign pci_bus_reset_n_s = sync_q[10];
  assign suspend_s = sync_q[11];
  assign reset_active = !rst_n || !pci_bus_reset_n_s;
  assign do_clear = reset_active && !suspend_s;
  assign gp_in = {pin_s[5], pin_s[4], pin_s[2], pin_s[1], pin_s[0]};
  assign req = avs_read || avs_write;
  // loader waits for the strap to be taken, then runs once per reset release while serial_en is set
  assign ld_start = s_reg.load_pending && s_reg.strap_taken && s_reg.serial_en && !reset_active;

  mfr_eeprom_loader u_loader (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(ld_start),
    .sda_in(pin_s[SDA_PIN]),
    .scl_oe(ld_scl_oe),
    .sda_oe(ld_sda_oe),
    .busy(ld_busy),
    .done(ld_done),
    .err(ld_err),
    .data(ld_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers, routing, outputs
  always_comb
  begin
    s_next = s_reg;
    func = MF_INPUT;
    rd = 32'h0000_0000;
    wold = 32'h0000_0000;
    case (avs_address)
      REG_ROUTE: rd = {4'h0, s_reg.route};
      REG_GP_OUT: rd = {27'h0, s_reg.gp_out};
      REG_GP_IN: rd = {27'h0, gp_in};
      REG_CTRL:
      begin
        rd[CTRL_PME_SEL_BIT] = s_reg.pme_sel;
        rd[STAT_SERIAL_EN_BIT] = s_reg.serial_en;
        rd[STAT_LD_BUSY_BIT] = ld_busy;
        rd[STAT_LD_DONE_BIT] = ld_done;
        rd[STAT_LD_ERR_BIT] = ld_err;
        rd[STAT_SUSPEND_BIT] = suspend_s;
      end
      REG_SUBSYS: rd = s_reg.subsys;
      default: rd = 32'h0000_0000;
    endcase
    case (avs_address)
      REG_ROUTE: wold = {4'h0, s_reg.route};
      REG_GP_OUT: wold = {27'h0, s_reg.gp_out};
      REG_CTRL: wold = {31'h0, s_reg.pme_sel};
      default: wold = 32'h0000_0000;
    endcase
    for (int b = 0; b < 4; b++)
      wmerge[b*8 +: 8] = avs_byteenable[b] ? avs_writedata[b*8 +: 8] : wold[b*8 +: 8];
    // one wait cycle, then the answer; unmapped reads give zero
    s_next.ack = req && !s_reg.ack;
    if (req && !s_reg.ack)
    begin
      if (avs_read)
        s_next.rdata = rd;
      if (avs_write)
        case (avs_address)
          REG_ROUTE: s_next.route = wmerge[27:0];
          REG_GP_OUT: s_next.gp_out = wmerge[GP_W-1:0];
          REG_CTRL: s_next.pme_sel = wmerge[CTRL_PME_SEL_BIT];
          default: s_next.ack = 1'b1;
        endcase
    end
    if (!s_reg.strap_taken)
    begin
      s_next.strap_taken = 1'b1;
      s_next.serial_en = !strap_s;
    end
    if (reset_active)
      s_next.load_pending = 1'b1;
    if (ld_start)
      s_next.load_pending = 1'b0;
    s_next.ld_done_q = ld_done;
    if (ld_done && !s_reg.ld_done_q && !ld_err)
      s_next.subsys = ld_data;
    for (int k = 0; k < NUM_PINS; k++)
    begin
      func = mfr_func_t'(s_reg.route[k*FUNC_W +: FUNC_W]);
      if (!PIN_ALLOWED[k][func])
        func = MF_INPUT;
      s_next.pin_out[k] = 1'b0;
      s_next.pin_oe[k] = 1'b1;
      case (func)
        MF_PAR_IRQ: s_next.pin_out[k] = core_in.par_irq[k];
        MF_GP_OUT: s_next.pin_out[k] = s_reg.gp_out[PIN_GP_IDX[k]];
        MF_LED: s_next.pin_out[k] = core_in.led;
        MF_VIDEO_SW: s_next.pin_out[k] = core_in.video_sw;
        MF_AUDIO_PWM: s_next.pin_out[k] = core_in.audio_pwm;
        MF_GP_EVENT: s_next.pin_out[k] = core_in.gp_event;
        MF_RING_OUT: s_next.pin_out[k] = core_in.ring;
        MF_LOW_POWER: s_next.pin_out[k] = core_in.low_power;
        // open-drain interrupt: pull low while requested
        MF_PCI_INT: s_next.pin_oe[k] = core_in.pci_int[k[0]];
        MF_PCI_LOCK:
        begin
          s_next.pin_out[k] = core_in.lock_o;
          s_next.pin_oe[k] = core_in.lock_oe;
        end
        MF_CLKRUN:
        begin
          s_next.pin_out[k] = core_in.clkrun_o;
          s_next.pin_oe[k] = core_in.clkrun_oe;
        end
        MF_SERIAL_IRQ:
        begin
          s_next.pin_out[k] = core_in.serirq_o;
          s_next.pin_oe[k] = core_in.serirq_oe;
        end
        default: s_next.pin_oe[k] = 1'b0;
      endcase
    end
    // serial bus takes precedence over the routing field
    if (s_reg.serial_en)
    begin
      s_next.pin_out[SDA_PIN] = 1'b0;
      s_next.pin_oe[SDA_PIN] = ld_sda_oe;
      s_next.pin_out[SCL_PIN] = 1'b0;
      s_next.pin_oe[SCL_PIN] = ld_scl_oe;
    end
    s_next.spk = ^spk_s;
    s_next.ring_pme = s_reg.pme_sel ? core_in.pme : core_in.ring;
    if (do_clear)
    begin
      s_next = '0;
      s_next.route = ROUTE_RST;
      s_next.gp_out = GP_OUT_RST;
      s_next.load_pending = 1'b1;
      // strap is a global-reset matter; a bus reset keeps it
      if (rst_n)
      begin
        s_next.strap_taken = s_reg.strap_taken;
        s_next.serial_en = s_reg.serial_en;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    s_reg <= s_next;
  end

  assign avs_waitrequest = req && !s_reg.ack;
  assign avs_readdata = s_reg.rdata;
  assign mf_pin_out = s_reg.pin_out;
  assign mf_pin_oe = s_reg.pin_oe;
  assign host_speaker_output = s_reg.spk;
  assign ring_indicate_output = s_reg.ring_pme;
  assign core_ret.lock_in = pin_s[4];
  assign core_ret.clkrun_in = pin_s[6];
  assign core_ret.serirq_in = pin_s[3];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_PIN0_INTA: assert property (
    (s_reg.route[3:0] == MF_PCI_INT) && !do_clear
    |=> mf_pin_oe[0] == $past(core_in.pci_int[0]) && !mf_pin_out[0])
    else $error("pin 0 does not follow INTA");
  AST_PIN1_GPO: assert property (
    (s_reg.route[7:4] == MF_GP_OUT) && !s_reg.serial_en && !do_clear
    |=> mf_pin_oe[1] && mf_pin_out[1] == $past(s_reg.gp_out[1]))
    else $error("pin 1 does not drive general output 1");
  AST_SDA_TAKEN: assert property (
    s_reg.serial_en && !do_clear |=> mf_pin_oe[SDA_PIN] == $past(ld_sda_oe) && !mf_pin_out[SDA_PIN])
    else $error("pin 1 not serving as serial data");
  AST_SCL_TAKEN: assert property (
    s_reg.serial_en && !do_clear |=> mf_pin_oe[SCL_PIN] == $past(ld_scl_oe) && !mf_pin_out[SCL_PIN])
    else $error("pin 4 not serving as serial clock");
  AST_LOAD_START: assert property (
    ld_start |=> ld_busy ##1 !s_reg.load_pending)
    else $error("eeprom load did not start after reset release");
  AST_PIN2_RING: assert property (
    (s_reg.route[11:8] == MF_RING_OUT) && !do_clear
    |=> mf_pin_oe[2] && mf_pin_out[2] == $past(core_in.ring))
    else $error("pin 2 does not carry ring output");
  AST_PIN3_DEFAULT: assert property (
    do_clear ##1 !do_clear |=> mf_pin_oe[3] == $past(core_in.serirq_oe))
    else $error("pin 3 not serialized interrupt after reset");
  AST_PIN4_LOCK: assert property (
    (s_reg.route[19:16] == MF_PCI_LOCK) && !s_reg.serial_en && !do_clear
    |=> mf_pin_oe[4] == $past(core_in.lock_oe) && mf_pin_out[4] == $past(core_in.lock_o))
    else $error("pin 4 does not carry LOCK");
  AST_PIN5_LOWPOW: assert property (
    (s_reg.route[23:20] == MF_LOW_POWER) && !do_clear
    |=> mf_pin_oe[5] && mf_pin_out[5] == $past(core_in.low_power))
    else $error("pin 5 does not carry low-power flag");
  AST_PIN6_CLKRUN: assert property (
    (s_reg.route[27:24] == MF_CLKRUN) && !do_clear
    |=> mf_pin_oe[6] == $past(core_in.clkrun_oe) && mf_pin_out[6] == $past(core_in.clkrun_o))
    else $error("pin 6 does not carry CLKRUN");
  AST_RING_PME: assert property (
    !do_clear |=> ring_indicate_output == ($past(s_reg.pme_sel) ? $past(core_in.pme) : $past(core_in.ring)))
    else $error("ring/pme output wrong source");
  AST_SPEAKER: assert property (
    $stable(card_speaker_input) [*3] ##0 !do_clear
    |=> host_speaker_output == ^$past(card_speaker_input, 3))
    else $error("speaker output is not the xor of card inputs");
  AST_SUSPEND_HOLDS: assert property (
    suspend_s && reset_active && !avs_write |=> $stable(s_reg.route) && $stable(s_reg.subsys))
    else $error("registers changed under suspend");
  AST_ILLEGAL_SAFE: assert property (
    !PIN_ALLOWED[0][s_reg.route[3:0]] && !do_clear |=> !mf_pin_oe[0])
    else $error("illegal select did not leave pin 0 as input");

  COV_EE_LOAD: cover property (ld_done && !s_reg.ld_done_q);
  COV_BUS_READ: cover property (avs_read && !avs_waitrequest);
  COV_SUSPEND_RESET: cover property (suspend_s && !pci_bus_reset_n_s);
  COV_PIN1_GPO: cover property (s_reg.route[7:4] == MF_GP_OUT && mf_pin_oe[1]);

endmodule // mfr_pin_router

// ---- core/mfr_pkg.sv ----
package mfr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_PINS = 7;
  localparam int FUNC_W = 4;
  localparam int GP_W = 5;
  localparam int ADDR_W = 5;
  localparam int SDA_PIN = 1;
  localparam int SCL_PIN = 4;

  ////////////////////////////////////////////////////////////////////////////
  // pin functions and the set each terminal accepts
  typedef enum logic [3:0] {
    MF_INPUT      = 4'h0,
    MF_PAR_IRQ    = 4'h1,
    MF_GP_IN      = 4'h2,
    MF_GP_OUT     = 4'h3,
    MF_LED        = 4'h4,
    MF_VIDEO_SW   = 4'h5,
    MF_AUDIO_PWM  = 4'h6,
    MF_GP_EVENT   = 4'h7,
    MF_RING_OUT   = 4'h8,
    MF_LOW_POWER  = 4'h9,
    MF_PCI_INT    = 4'ha,
    MF_PCI_LOCK   = 4'hb,
    MF_CLKRUN     = 4'hc,
    MF_SERIAL_IRQ = 4'hd
  } mfr_func_t;

  localparam logic [NUM_PINS-1:0][15:0] PIN_ALLOWED = {
    16'h1003, 16'h02ff, 16'h0bff, 16'h2003, 16'h03ff, 16'h04ff, 16'h04ff
  };
  localparam logic [NUM_PINS-1:0][2:0] PIN_GP_IDX = {
    3'h0, 3'h4, 3'h3, 3'h0, 3'h2, 3'h1, 3'h0
  };

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [ADDR_W-1:0] REG_ROUTE = 5'h00;
  localparam logic [ADDR_W-1:0] REG_GP_OUT = 5'h04;
  localparam logic [ADDR_W-1:0] REG_GP_IN = 5'h08;
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_SUBSYS = 5'h10;
  localparam logic [27:0] ROUTE_RST = 28'h000d000;
  localparam logic [GP_W-1:0] GP_OUT_RST = 5'h00;
  localparam int CTRL_PME_SEL_BIT = 0;
  localparam int STAT_SERIAL_EN_BIT = 8;
  localparam int STAT_LD_BUSY_BIT = 9;
  localparam int STAT_LD_DONE_BIT = 10;
  localparam int STAT_LD_ERR_BIT = 11;
  localparam int STAT_SUSPEND_BIT = 12;

  ////////////////////////////////////////////////////////////////////////////
  // serial eeprom loader
  localparam logic [7:0] EE_DEV_WR = 8'ha0;
  localparam logic [7:0] EE_DEV_RD = 8'ha1;
  localparam logic [7:0] EE_WORD_ADDR = 8'h00;
  localparam logic [2:0] EE_RESTART_FRAME = 3'h2;
  localparam logic [2:0] EE_FIRST_READ = 3'h3;
  localparam logic [2:0] EE_LAST_FRAME = 3'h6;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_QUARTER_NS = 2500;
  localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] QUARTER_CNT_MAX = 8'(SCL_QUARTER_CYC - 1);

  typedef enum logic [2:0] {
    LD_IDLE  = 3'b000,
    LD_START = 3'b001,
    LD_BIT   = 3'b011,
    LD_STOP  = 3'b010,
    LD_DONE  = 3'b110
  } mfr_ld_fsm_t;

  typedef struct packed {
    mfr_ld_fsm_t fsm;
    logic [7:0] qcnt;
    logic [1:0] q;
    logic [3:0] bit_i;
    logic [2:0] frame;
    logic [7:0] shreg;
    logic [31:0] data;
    logic scl_oe;
    logic sda_oe;
    logic err;
    logic done;
  } mfr_ld_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [NUM_PINS-1:0] par_irq;
    logic [1:0] pci_int;
    logic led;
    logic video_sw;
    logic audio_pwm;
    logic gp_event;
    logic ring;
    logic pme;
    logic low_power;
    logic lock_o;
    logic lock_oe;
    logic clkrun_o;
    logic clkrun_oe;
    logic serirq_o;
    logic serirq_oe;
  } mfr_core_t;

  typedef struct packed {
    logic lock_in;
    logic clkrun_in;
    logic serirq_in;
  } mfr_ret_t;

  typedef struct packed {
    logic [27:0] route;
    logic [GP_W-1:0] gp_out;
    logic pme_sel;
    logic [31:0] subsys;
    logic strap_taken;
    logic serial_en;
    logic load_pending;
    logic ld_done_q;
    logic ack;
    logic [31:0] rdata;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe;
    logic spk;
    logic ring_pme;
  } mfr_state_t;

endpackage

// ---- core/mfr_sync.sv ----
`timescale 1ns/100ps
module mfr_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // no reset: suspend must pass through even while reset is low
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge ref_clk)
  begin
    meta_reg <= d;
    q_reg <= meta_reg;
  end

  assign q = q_reg;
endmodule // mfr_sync
